// ---- hw/doorbell_deactivation_monitor.sv ----
// What this block does
// - Device sees deactivation when a snooped line shows active flag cleared.
// - On deactivation, compare cookies to decide a final last-moment ring.
// - After deactivation, clear valid bit and stop matching that line.
// - Valid clears only after all earlier line updates are registered.
// - Zero or unchanged cookie is no ring; other cookie sets status bit.
// - Notify scheduler only when the ring's 32-bit group was all zero or is read in the same cycle.
// - Scheduler reading a status group clears that group.
module doorbell_deactivation_monitor
    import doorbell_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // Scheduler arms a doorbell (valid 0 to 1)
    input  wire logic                  arm_valid,
    input  wire logic [5:0]            arm_bell,
    // Snooped line data: first two dwords of the cacheline
    input  wire logic                  snoop_valid,
    input  wire logic [5:0]            snoop_bell,
    input  wire logic [31:0]           snoop_dw0,
    input  wire logic [31:0]           snoop_dw1,
    output logic                       snoop_ready,
    // Status vector read port, one group per read
    input  wire logic                  status_read,
    input  wire logic                  status_group,
    output logic [31:0]                status_data,
    // Per-doorbell state seen by driver and scheduler
    output logic [63:0]                bell_valid,
    output logic [63:0]                deact_status,
    input  wire logic [63:0]           deact_status_clr,
    output logic [1:0]                 notify
);
    eval_state_t  state_reg;
    eval_state_t  state_next;
    logic [5:0]   bell_reg;
    logic [5:0]   bell_next;
    logic         active_reg;
    logic         active_next;
    logic [31:0]  cookie_reg;
    logic [31:0]  cookie_next;
    logic [31:0]  stored_reg [NUM_BELLS];
    logic [63:0]  valid_reg;
    logic [63:0]  valid_next;
    logic [63:0]  deact_reg;
    logic [63:0]  deact_next;
    logic         ring;
    logic [31:0]  group_vec [NUM_GROUPS];

    // Cookie classification, used by evaluation only; checks spell out their own conditions
    function automatic logic is_ring(input logic [31:0] seen, input logic [31:0] kept);
        is_ring = (seen != COOKIE_INIT) && (seen != kept);
    endfunction : is_ring

    assign ring = (state_reg == ST_EVAL) && is_ring(cookie_reg, stored_reg[bell_reg]);

    // One snoop in flight at a time keeps updates ordered
    assign snoop_ready = (state_reg == ST_IDLE);

    // Evaluation sequencer
    always_comb
    begin
        state_next  = state_reg;
        bell_next   = bell_reg;
        active_next = active_reg;
        cookie_next = cookie_reg;
        valid_next  = valid_reg;
        deact_next  = deact_reg & ~deact_status_clr;
        if (arm_valid)
        begin
            valid_next[arm_bell] = 1'b1;
        end
        case (state_reg)
            ST_IDLE:
            begin
                if (snoop_valid && valid_reg[snoop_bell])
                begin
                    bell_next   = snoop_bell;
                    active_next = snoop_dw0[ACTIVE_FLAG_BIT];
                    cookie_next = snoop_dw1;
                    state_next  = ST_EVAL;
                end
            end
            ST_EVAL:
            begin
                if (!active_reg)
                begin
                    if (ring)
                    begin
                        deact_next[bell_reg] = 1'b1;
                    end
                    state_next = ST_RETIRE;
                end
                else
                begin
                    state_next = ST_IDLE;
                end
            end
            ST_RETIRE:
            begin
                valid_next[bell_reg] = 1'b0;
                state_next           = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg  <= ST_IDLE;
            bell_reg   <= '0;
            active_reg <= 1'b0;
            cookie_reg <= COOKIE_INIT;
            valid_reg  <= '0;
            deact_reg  <= '0;
        end
        else
        begin
            state_reg  <= state_next;
            bell_reg   <= bell_next;
            active_reg <= active_next;
            cookie_reg <= cookie_next;
            valid_reg  <= valid_next;
            deact_reg  <= deact_next;
        end
    end

    // Stored cookie array; arming resets it to the driver's initial value
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < NUM_BELLS; i++)
            begin
                stored_reg[i] <= COOKIE_INIT;
            end
        end
        else
        begin
            if (arm_valid)
            begin
                stored_reg[arm_bell] <= COOKIE_INIT;
            end
            if (state_reg == ST_EVAL)
            begin
                stored_reg[bell_reg] <= cookie_reg;
            end
        end
    end

    // Status groups; active flag state does not gate the ring itself
    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++)
        begin : gen_group
            doorbell_group_status u_doorbell_group_status (
                .clk     (clk),
                .nrst    (nrst),
                .set_en  (ring && bell_reg[5] == 1'(g)),
                .set_bit (bell_reg[4:0]),
                .read_en (status_read && status_group == 1'(g)),
                .vec     (group_vec[g]),
                .notify  (notify[g])
            );
        end
    endgenerate

    assign status_data  = group_vec[status_group];
    assign bell_valid   = valid_reg;
    assign deact_status = deact_reg;

    AST_NO_MATCH_AFTER_RETIRE: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ST_IDLE && snoop_valid && !valid_reg[snoop_bell])
        |=> state_reg == ST_IDLE)
        else $error("snoop matched a doorbell with valid clear");
    // valid drops two cycles after an inactive snoop is evaluated
    AST_RETIRE_TIMING: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ST_EVAL && !active_reg && !arm_valid)
        |=> state_reg == ST_RETIRE ##1 !valid_reg[$past(bell_reg, 2)])
        else $error("valid bit not cleared after deactivation");
    // one snoop in flight keeps updates ordered
    AST_ONE_IN_FLIGHT: assert property (@(posedge clk) disable iff (!nrst)
        (snoop_ready && snoop_valid && valid_reg[snoop_bell]) |=> !snoop_ready)
        else $error("second snoop accepted while one is in flight");
    // deactivation with new cookie flags status, even against a clear
    AST_DEACT_STATUS: assert property (@(posedge clk) disable iff (!nrst)
        (ring && !active_reg) |=> deact_reg[$past(bell_reg)])
        else $error("last-moment ring not flagged");
    AST_ZERO_NO_RING: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ST_EVAL && cookie_reg == COOKIE_INIT) |=> notify == 2'b00)
        else $error("zero cookie treated as ring");
    AST_SAME_NO_RING: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ST_EVAL && cookie_reg == stored_reg[bell_reg]) |=> notify == 2'b00)
        else $error("unchanged cookie treated as ring");
    AST_STORE_COOKIE: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == ST_EVAL && !arm_valid)
        |=> stored_reg[$past(bell_reg)] == $past(cookie_reg))
        else $error("stored cookie not updated");
    AST_INACTIVE_RETIRES: assert property (@(posedge clk) disable iff (!nrst)
        (snoop_ready && snoop_valid && valid_reg[snoop_bell] && !snoop_dw0[ACTIVE_FLAG_BIT])
        |=> ##1 state_reg == ST_RETIRE)
        else $error("deactivation not recognised");

    COV_RING: cover property (@(posedge clk) disable iff (!nrst) ring && active_reg);
    COV_LAST_RING: cover property (@(posedge clk) disable iff (!nrst) ring && !active_reg);
    COV_RETIRE: cover property (@(posedge clk) disable iff (!nrst) state_reg == ST_RETIRE);
endmodule : doorbell_deactivation_monitor

// ---- hw/doorbell_pkg.sv ----
package doorbell_pkg;
    // Sizing of the doorbell array and status groups
    localparam int unsigned NUM_BELLS    = 64;
    localparam int unsigned BELL_IDX_W   = 6;
    localparam int unsigned GROUP_W      = 32;
    localparam int unsigned NUM_GROUPS   = NUM_BELLS / GROUP_W;
    localparam int unsigned GROUP_IDX_W  = 1;
    localparam int unsigned COOKIE_W     = 32;
    // Field positions within the snooped line
    localparam int unsigned ACTIVE_FLAG_BIT = 0;
    // Reset and reserved values
    localparam logic [31:0] COOKIE_INIT  = 32'h0000_0000;
    localparam logic [31:0] GROUP_EMPTY  = 32'h0000_0000;
    // Evaluation pipeline states
    typedef enum logic [1:0] {ST_IDLE, ST_EVAL, ST_RETIRE} eval_state_t;
endpackage : doorbell_pkg

// ---- hw/doorbell_group_status.sv ----
module doorbell_group_status
    import doorbell_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               set_en,
    input  wire logic [4:0]         set_bit,
    input  wire logic               read_en,
    output logic      [31:0]        vec,
    output logic                    notify
);
    logic [31:0] vec_reg;
    logic [31:0] vec_next;
    logic        notify_reg;
    logic        notify_next;

    // Read clears group; a ring in the same cycle survives
    always_comb
    begin
        vec_next    = vec_reg;
        notify_next = 1'b0;
        if (read_en)
        begin
            vec_next = GROUP_EMPTY;
        end
        if (set_en)
        begin
            vec_next[set_bit] = 1'b1;
            notify_next = (read_en || vec_reg == GROUP_EMPTY);
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            vec_reg    <= GROUP_EMPTY;
            notify_reg <= 1'b0;
        end
        else
        begin
            vec_reg    <= vec_next;
            notify_reg <= notify_next;
        end
    end

    assign vec    = vec_reg;
    assign notify = notify_reg;

    // message only when group was empty or is read in the same cycle
    AST_NOTIFY_EMPTY: assert property (@(posedge clk) disable iff (!nrst)
        (set_en && !read_en && vec_reg != GROUP_EMPTY) |=> !notify)
        else $error("notify raised for a non-empty group");
    AST_READ_CLEARS: assert property (@(posedge clk) disable iff (!nrst)
        (read_en && !set_en) |=> vec == GROUP_EMPTY)
        else $error("group not cleared by read");
    COV_NOTIFY: cover property (@(posedge clk) disable iff (!nrst) notify);
endmodule : doorbell_group_status

// ---- verification/host_bell_model.sv ----
// Host threads and driver as seen through the snooped line
module host_bell_model
    import doorbell_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        snoop_ready,
    output logic             snoop_valid,
    output logic [5:0]       snoop_bell,
    output logic [31:0]      snoop_dw0,
    output logic [31:0]      snoop_dw1
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] cookie_mem [64];
    logic        flag_mem   [64];

    // Idle lines at time zero
    initial
    begin
        snoop_valid = 1'b0;
        snoop_bell  = 6'h00;
        snoop_dw0   = 32'h0000_0000;
        snoop_dw1   = 32'h0000_0000;
    end

    // driver initialises cookie and raises the flag
    task automatic set_cookie(input logic [5:0] b, input logic [31:0] v);
        cookie_mem[b] = v;
        flag_mem[b]   = 1'b1;
    endtask : set_cookie

    task automatic bump(input logic [5:0] b);
        cookie_mem[b] = cookie_mem[b] + 32'h0000_0001;
        if (cookie_mem[b] == 32'h0000_0000)
            cookie_mem[b] = 32'h0000_0001;
    endtask : bump

    // Shared-bell thread ring from a guessed cookie; bounded retries
    task automatic cas_ring(input logic [5:0] b, input logic [31:0] guess, output bit lost);
        logic [31:0] seen;
        bit          done;
        seen = guess;
        done = 1'b0;
        lost = 1'b0;
        for (int i = 0; i < 4 && !done && !lost; i++)
        begin
            // flag zero: no write, thread asks for a new bell
            if (!flag_mem[b])
                lost = 1'b1;
            // exchange succeeds, cookie advances past zero
            else if (cookie_mem[b] == seen)
            begin
                cookie_mem[b] = (seen == 32'hffff_ffff) ? 32'h0000_0001 : seen + 32'h0000_0001;
                done          = 1'b1;
            end
            // stale guess: retry from the returned cookie
            else
                seen = cookie_mem[b];
        end
    endtask : cas_ring

    // flag and cookie as one quadword; flag 0 retires
    task automatic offer(input logic [5:0] b, input logic flag, output bit ok);
        int n;
        n = 0;
        @(negedge clk);
        snoop_valid = 1'b1;
        snoop_bell  = b;
        snoop_dw0   = {31'h0000_0000, flag};
        snoop_dw1   = cookie_mem[b];
        // a cleared flag means the driver retired the bell
        if (!flag)
            flag_mem[b] = 1'b0;
        while (!snoop_ready && n < 8)
        begin
            @(negedge clk);
            n++;
        end
        // Never offer past a refused slot; a stuck ready is a hang
        ok = snoop_ready;
        @(posedge clk);
        @(negedge clk);
        snoop_valid = 1'b0;
        // Released lines must not keep showing the last value
        snoop_dw0   = ~snoop_dw0;
        snoop_dw1   = ~snoop_dw1;
        while (!snoop_ready && n < 16)
        begin
            @(negedge clk);
            n++;
        end
        ok = ok && (n < 16);
    endtask : offer
endmodule : host_bell_model

// ---- verification/test_doorbell_deactivation_monitor.sv ----
module test_doorbell_deactivation_monitor
    import doorbell_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, nrst, arm_valid, snoop_valid, snoop_ready, status_read, status_group;
    logic [5:0]  arm_bell, snoop_bell;
    logic [31:0] snoop_dw0, snoop_dw1, status_data;
    logic [63:0] bell_valid, deact_status, deact_status_clr;
    logic [1:0]  notify;
    int          num_errors = 0;
    int          compares = 0;
    bit          lost;

    doorbell_deactivation_monitor u_doorbell_deactivation_monitor (.clk(clk), .nrst(nrst),
        .arm_valid(arm_valid), .arm_bell(arm_bell), .snoop_valid(snoop_valid),
        .snoop_bell(snoop_bell), .snoop_dw0(snoop_dw0), .snoop_dw1(snoop_dw1),
        .snoop_ready(snoop_ready), .status_read(status_read), .status_group(status_group),
        .status_data(status_data), .bell_valid(bell_valid), .deact_status(deact_status),
        .deact_status_clr(deact_status_clr), .notify(notify));

    host_bell_model u_host_bell_model (.clk(clk), .snoop_ready(snoop_ready),
        .snoop_valid(snoop_valid), .snoop_bell(snoop_bell), .snoop_dw0(snoop_dw0),
        .snoop_dw1(snoop_dw1));

    // 100 MHz clock
    always #5 clk = ~clk;

    task automatic summarize();
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Snoop with bounded wait; a hang ends the run
    task automatic snoop(input logic [5:0] b, input logic flag, input logic bump_it);
        bit ok;
        if (bump_it)
            u_host_bell_model.bump(b);
        u_host_bell_model.offer(b, flag, ok);
        if (!ok)
        begin
            num_errors++;
            summarize();
        end
    endtask : snoop

    task automatic arm(input logic [5:0] b);
        @(negedge clk);
        arm_valid = 1'b1;
        arm_bell  = b;
        u_host_bell_model.set_cookie(b, 32'h0000_0000);
        @(negedge clk);
        arm_valid = 1'b0;
    endtask : arm

    // Read-and-clear of one status group
    task automatic rd(input logic g, input logic [31:0] exp);
        @(negedge clk);
        status_group = g;
        status_read  = 1'b1;
        // Let the group select settle before looking
        #1;
        chk(status_data, exp);
        @(negedge clk);
        status_read  = 1'b0;
    endtask : rd

    // Main sequence
    initial
    begin
        {clk, nrst, arm_valid, status_read, status_group} = 5'h00;
        arm_bell = 6'h00;
        deact_status_clr = 64'h0;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        arm(6'd3);
        chk(bell_valid[3], 1'b1);
        snoop(6'd3, 1'b1, 1'b0);
        rd(1'b0, 32'h0000_0000);
        snoop(6'd3, 1'b1, 1'b1);
        chk(notify, 2'h1);
        snoop(6'd3, 1'b1, 1'b1);
        chk(notify, 2'h0);
        snoop(6'd3, 1'b1, 1'b0);
        rd(1'b0, 32'h0000_0008);
        rd(1'b0, 32'h0000_0000);
        u_host_bell_model.set_cookie(6'd3, 32'hffff_ffff);
        snoop(6'd3, 1'b1, 1'b0);
        rd(1'b0, 32'h0000_0008);
        snoop(6'd3, 1'b1, 1'b1);
        chk(notify, 2'h1);
        rd(1'b0, 32'h0000_0008);
        arm(6'd40);
        snoop(6'd40, 1'b1, 1'b1);
        chk(notify, 2'h2);
        rd(1'b1, 32'h0000_0100);
        u_host_bell_model.cas_ring(6'd40, 32'h0000_0000, lost);
        snoop(6'd40, 1'b1, 1'b0);
        chk(notify, 2'h2);
        rd(1'b1, 32'h0000_0100);
        snoop(6'd3, 1'b0, 1'b1);
        chk(deact_status[3], 1'b1);
        chk(bell_valid[3], 1'b0);
        rd(1'b0, 32'h0000_0008);
        u_host_bell_model.cas_ring(6'd3, 32'h0000_0002, lost);
        snoop(6'd3, 1'b1, 1'b1);
        rd(1'b0, 32'h0000_0000);
        @(negedge clk);
        deact_status_clr = 64'h8;
        @(negedge clk);
        deact_status_clr = 64'h0;
        chk(deact_status[3], 1'b0);
        // the thread that lost its bell is given one again
        if (lost)
            arm(6'd3);
        snoop(6'd40, 1'b0, 1'b0);
        chk(deact_status[40], 1'b0);
        chk(bell_valid, 64'h8);
        summarize();
    end
endmodule : test_doorbell_deactivation_monitor
